// ### link_regs_defines.svh
/*
 * Register offsets, field positions, reset values and widths for the
 * link identification and interrupt map register bank.
 * Assumes it is included by bare name; definitions only.
 */
`ifndef LINK_REGS_DEFINES_SVH
`define LINK_REGS_DEFINES_SVH

`define ADDR_W 8
`define DATA_W 32

`define OFS_PART_IDENTIFICATION 8'h40
`define OFS_LINK_GENERATION_STATUS 8'h44
`define OFS_MODE_CAPABILITY_MASK 8'h4C
`define OFS_IRQ_MAP_INPUTS_LOW 8'h60
`define OFS_IRQ_MAP_INPUTS_HIGH 8'h64
`define OFS_REMOTE_BASE 8'h80

`define PART_REV_MSB 31
`define PART_REV_LSB 16
`define PART_ID_MSB 15
`define PART_ID_LSB 0
`define LINK_GEN2_BIT 16
`define MODE_CAPABILITY_VALUE 32'h0000_0001

`define IRQ_NUM_INPUTS 8
`define IRQ_FIELD_W 8
`define IRQ_ENABLE_BIT 7
`define IRQ_TYPE_BIT 6
`define IRQ_POLARITY_BIT 5
`define IRQ_VECTOR_MSB 4
`define IRQ_VECTOR_LSB 0
`define IRQ_MAP_RESET 32'h0000_0000

`endif

// ### link_regs_pkg.sv
/*
 * Types shared by the register bank and its helpers.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package link_regs_pkg;

	typedef enum logic [0:0] {
		REMOTE_IDLE,
		REMOTE_WAIT
	} remote_state_t;

	typedef logic [31:0] word_t;

endpackage : link_regs_pkg

// ### irq_input_detect.sv
/*
 * Synchronises the external interrupt inputs and detects, per input,
 * either the entry into the active level (pulsed) or the level itself.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps

module irq_input_detect #(
	parameter int NUM = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [NUM-1:0] raw_in,
	input wire logic [NUM-1:0] active_low,
	input wire logic [NUM-1:0] pulsed,
	output logic [NUM-1:0] fire
);
	import link_regs_pkg::*;

	logic [NUM-1:0] meta_q, meta_d;
	logic [NUM-1:0] sync_q, sync_d;
	logic [NUM-1:0] last_q, last_d;

	// meta_q feeds only sync_q
	always_comb begin
		meta_d = raw_in;
		sync_d = meta_q;
		last_d = sync_q;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			meta_q <= '0;
			sync_q <= '0;
			last_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			last_q <= last_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < NUM; i++) begin : g_det
			logic now_active;
			logic was_active;
			assign now_active = sync_q[i] ^ active_low[i]; // see [R8]
			assign was_active = last_q[i] ^ active_low[i];
			// pulsed: entry into active level; level: every active cycle
			assign fire[i] = pulsed[i] ? (now_active & ~was_active) : now_active; // see [R7] see [R12]
		end
	endgenerate

endmodule : irq_input_detect

// ### remote_config_port.sv
/*
 * Forwards one access of the upper register window to the link engine as a
 * configuration transfer and waits for its completion.
 * Assumes the engine holds remote_done high for one cycle per request.
 */
`timescale 1ns/1ps

module remote_config_port (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic start_we,
	input wire logic [6:0] start_offset,
	input wire link_regs_pkg::word_t start_wdata,
	output logic busy,
	output logic finish,
	output link_regs_pkg::word_t finish_rdata,
	output logic remote_req,
	output logic remote_we,
	output logic [6:0] remote_offset,
	output link_regs_pkg::word_t remote_wdata,
	input wire logic remote_done,
	input wire link_regs_pkg::word_t remote_rdata
);
	import link_regs_pkg::*;

	remote_state_t state_q, state_d;
	logic we_q, we_d;
	logic [6:0] ofs_q, ofs_d;
	word_t wdata_q, wdata_d;
	word_t rdata_q, rdata_d;
	logic fin_q, fin_d;

	always_comb begin
		state_d = state_q;
		we_d = we_q;
		ofs_d = ofs_q;
		wdata_d = wdata_q;
		rdata_d = rdata_q;
		fin_d = 1'b0;
		unique case (state_q)
			REMOTE_IDLE: begin
				if (start) begin
					state_d = REMOTE_WAIT;
					we_d = start_we;
					ofs_d = start_offset;
					wdata_d = start_wdata;
				end
			end
			REMOTE_WAIT: begin
				if (remote_done) begin
					state_d = REMOTE_IDLE;
					rdata_d = we_q ? 32'h0000_0000 : remote_rdata;
					fin_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q <= REMOTE_IDLE;
			we_q <= 1'b0;
			ofs_q <= 7'h00;
			wdata_q <= 32'h0000_0000;
			rdata_q <= 32'h0000_0000;
			fin_q <= 1'b0;
		end else begin
			state_q <= state_d;
			we_q <= we_d;
			ofs_q <= ofs_d;
			wdata_q <= wdata_d;
			rdata_q <= rdata_d;
			fin_q <= fin_d;
		end
	end

	// no translation registers take part: the offset goes out as is
	assign remote_req = (state_q == REMOTE_WAIT); // see [R11]
	assign remote_we = we_q;
	assign remote_offset = ofs_q;
	assign remote_wdata = wdata_q;
	assign busy = (state_q == REMOTE_WAIT) | fin_q;
	assign finish = fin_q;
	assign finish_rdata = rdata_q;

endmodule : remote_config_port

// ### link_id_and_interrupt_map_regs.sv
/*
 * Identification, link-generation and capability registers plus the two
 * interrupt map registers of the serial bridge, with a window that forwards
 * accesses to the remote peer's register set.
 * Assumes one core clock, a synchronous active-high reset, a link engine that
 * owns the pending/set register and raises the interrupt, and a simple
 * strobe-based register port driven by local software.
 */
`timescale 1ns/1ps
`include "link_regs_defines.svh"

// Notes on behaviour
// [R1] identification register: upper half live revision input, lower half live identifier input.
// [R2] generation bit reads 1 for a second-generation peer, 0 for first-generation.
// [R3] capability mask register always reads one: only mode zero supported.
// [R4] reserved bits read zero; writes to them change nothing.
// [R5] enabled inputs record detected interrupts into pending/set; disabled inputs record nothing.
// [R6] a recorded interrupt raises an interrupt routed by the engine's local-routing bit.
// [R7] type bit set means pulsed input; clear means level sensitive.
// [R8] polarity bit set means active low; clear means active high.
// [R9] five-bit vector selects which pending/set bit the input sets.
// [R10] inputs 0-3 control bytes at 0x60, 4-7 at 0x64: enable, type, polarity, vector.
// [R11] upper window reaches the peer's registers by configuration transfers, no translation.
// [R12] inputs are synchronised; pulsed ones edge-detected, level ones sampled as level.
module link_id_and_interrupt_map_regs #(
	parameter int NUM_IRQ = `IRQ_NUM_INPUTS
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_sel,
	input wire logic reg_we,
	input wire logic [`ADDR_W-1:0] reg_addr,
	input wire link_regs_pkg::word_t reg_wdata,
	output link_regs_pkg::word_t reg_rdata,
	output logic reg_ack,
	output logic reg_busy,
	input wire logic [15:0] part_identifier_input,
	input wire logic [15:0] part_revision_input,
	input wire logic link_gen2,
	input wire logic [NUM_IRQ-1:0] external_irq_inputs,
	output link_regs_pkg::word_t pend_set_mask,
	output logic pend_set_valid,
	output logic remote_req,
	output logic remote_we,
	output logic [6:0] remote_offset,
	output link_regs_pkg::word_t remote_wdata,
	input wire logic remote_done,
	input wire link_regs_pkg::word_t remote_rdata
);
	import link_regs_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// register port decode

	logic take;
	logic is_remote;
	logic remote_busy;
	logic remote_finish;
	word_t remote_result;

	// new accesses are ignored while a remote transfer is outstanding
	assign take = reg_sel & ~remote_busy;
	assign is_remote = reg_addr[7];
	assign reg_busy = remote_busy;

	////////////////////////////////////////////////////////////////////////////
	// interrupt map registers

	logic [2*`DATA_W-1:0] map_q, map_d;

	always_comb begin
		map_d = map_q;
		if (take && reg_we && !is_remote) begin
			if (reg_addr == `OFS_IRQ_MAP_INPUTS_LOW) begin
				map_d[`DATA_W-1:0] = reg_wdata; // see [R10]
			end
			if (reg_addr == `OFS_IRQ_MAP_INPUTS_HIGH) begin
				map_d[2*`DATA_W-1:`DATA_W] = reg_wdata; // see [R10]
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			map_q <= {`IRQ_MAP_RESET, `IRQ_MAP_RESET};
		end else begin
			map_q <= map_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// per-input field extraction and vector decode

	logic [NUM_IRQ-1:0] irq_enable;
	logic [NUM_IRQ-1:0] irq_pulsed;
	logic [NUM_IRQ-1:0] irq_active_low;
	logic [NUM_IRQ-1:0] irq_fire;
	word_t irq_onehot [NUM_IRQ];

	genvar g;
	generate
		for (g = 0; g < NUM_IRQ; g++) begin : g_irq
			logic [`IRQ_FIELD_W-1:0] ctl;
			logic [4:0] vec;
			assign ctl = map_q[g*`IRQ_FIELD_W +: `IRQ_FIELD_W];
			assign irq_enable[g] = ctl[`IRQ_ENABLE_BIT];
			assign irq_pulsed[g] = ctl[`IRQ_TYPE_BIT]; // see [R7]
			assign irq_active_low[g] = ctl[`IRQ_POLARITY_BIT]; // see [R8]
			assign vec = ctl[`IRQ_VECTOR_MSB:`IRQ_VECTOR_LSB];
			// disabled inputs contribute nothing to the pending/set word
			assign irq_onehot[g] = (irq_fire[g] && irq_enable[g]) ?
				(32'h0000_0001 << vec) : 32'h0000_0000; // see [R5] see [R9]
		end
	endgenerate

	irq_input_detect #(
		.NUM(NUM_IRQ)
	) u_detect (
		.clk(clk),
		.sys_rst(sys_rst),
		.raw_in(external_irq_inputs),
		.active_low(irq_active_low),
		.pulsed(irq_pulsed),
		.fire(irq_fire)
	);

	////////////////////////////////////////////////////////////////////////////
	// pending/set write toward the link engine

	word_t set_q, set_d;
	logic set_valid_q, set_valid_d;

	always_comb begin
		set_d = 32'h0000_0000;
		for (int i = 0; i < NUM_IRQ; i++) begin
			set_d = set_d | irq_onehot[i];
		end
		// several inputs may share a vector; they merge into one bit
		set_valid_d = |set_d; // see [R5] see [R6]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			set_q <= 32'h0000_0000;
			set_valid_q <= 1'b0;
		end else begin
			set_q <= set_d;
			set_valid_q <= set_valid_d;
		end
	end

	// the engine sets these pending bits and raises the interrupt per its routing bit
	assign pend_set_mask = set_q; // see [R6]
	assign pend_set_valid = set_valid_q;

	////////////////////////////////////////////////////////////////////////////
	// remote window

	remote_config_port u_remote (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(take & is_remote), // see [R11]
		.start_we(reg_we),
		.start_offset(reg_addr[6:0]),
		.start_wdata(reg_wdata),
		.busy(remote_busy),
		.finish(remote_finish),
		.finish_rdata(remote_result),
		.remote_req(remote_req),
		.remote_we(remote_we),
		.remote_offset(remote_offset),
		.remote_wdata(remote_wdata),
		.remote_done(remote_done),
		.remote_rdata(remote_rdata)
	);

	////////////////////////////////////////////////////////////////////////////
	// local read mux and answer

	word_t local_word;

	always_comb begin
		local_word = 32'h0000_0000; // see [R4]
		unique case (reg_addr)
			`OFS_PART_IDENTIFICATION: begin
				local_word[`PART_REV_MSB:`PART_REV_LSB] = part_revision_input; // see [R1]
				local_word[`PART_ID_MSB:`PART_ID_LSB] = part_identifier_input; // see [R1]
			end
			`OFS_LINK_GENERATION_STATUS: begin
				local_word[`LINK_GEN2_BIT] = link_gen2; // see [R2]
			end
			`OFS_MODE_CAPABILITY_MASK: begin
				local_word = `MODE_CAPABILITY_VALUE; // see [R3]
			end
			`OFS_IRQ_MAP_INPUTS_LOW: begin
				local_word = map_q[`DATA_W-1:0];
			end
			`OFS_IRQ_MAP_INPUTS_HIGH: begin
				local_word = map_q[2*`DATA_W-1:`DATA_W];
			end
			default: begin
				local_word = 32'h0000_0000;
			end
		endcase
	end

	word_t rdata_q, rdata_d;
	logic ack_q, ack_d;

	always_comb begin
		rdata_d = rdata_q;
		ack_d = 1'b0;
		if (remote_finish) begin
			rdata_d = remote_result;
			ack_d = 1'b1;
		end else if (take && !is_remote) begin
			// writes to read-only or unmapped offsets are acknowledged and dropped
			rdata_d = reg_we ? 32'h0000_0000 : local_word; // see [R4]
			ack_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= 32'h0000_0000;
			ack_q <= 1'b0;
		end else begin
			rdata_q <= rdata_d;
			ack_q <= ack_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign reg_ack = ack_q;

endmodule : link_id_and_interrupt_map_regs

// ### link_regs_chk.sv
/*
 * Port checker for the link register bank.
 * Assumes it is bound to the bank and sees only its top-level ports.
 */
`timescale 1ns/1ps
module link_regs_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic reg_sel,
	input wire logic reg_we,
	input wire logic [7:0] reg_addr,
	input wire link_regs_pkg::word_t reg_rdata,
	input wire logic reg_ack,
	input wire logic reg_busy,
	input wire logic [15:0] part_identifier_input,
	input wire logic [15:0] part_revision_input,
	input wire logic link_gen2,
	input wire link_regs_pkg::word_t pend_set_mask,
	input wire logic pend_set_valid,
	input wire logic remote_req,
	input wire logic remote_we,
	input wire logic [6:0] remote_offset,
	input wire logic remote_done
);
	import link_regs_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	logic tk;
	// a request only counts while no remote transfer is outstanding
	assign tk = reg_sel && !reg_busy;
	////////////////////////////////////////////////////////////////////////////////
	a_local_ack: assert property (tk && !reg_addr[7] |=> reg_ack)
		else $error("local access not acked");
	a_id_read: assert property (tk && !reg_we && reg_addr == 8'h40 |=>
		reg_rdata == {$past(part_revision_input), $past(part_identifier_input)})
		else $error("identification read wrong");
	a_gen_read: assert property (tk && !reg_we && reg_addr == 8'h44 |=>
		reg_rdata == {15'h0, $past(link_gen2), 16'h0}) else $error("generation read wrong");
	a_cap_read: assert property (tk && !reg_we && reg_addr == 8'h4C |=>
		reg_rdata == 32'h1) else $error("capability read wrong");
	a_write_zero: assert property (tk && reg_we && !reg_addr[7] |=>
		reg_rdata == 32'h0) else $error("write returned data");
	a_remote_start: assert property (tk && reg_addr[7] |=> remote_req && reg_busy &&
		remote_offset == $past(reg_addr[6:0]) && remote_we == $past(reg_we))
		else $error("remote transfer not started");
	a_remote_hold: assert property (remote_req && !remote_done |=>
		remote_req && $stable(remote_offset)) else $error("remote request dropped");
	// the finish flag is registered once more, so the ack trails done by two edges
	a_remote_ack: assert property (remote_req && remote_done |=>
		!remote_req && reg_busy ##1 reg_ack && !reg_busy) else $error("remote answer wrong");
	a_irq_mask: assert property (pend_set_valid |-> pend_set_mask != 32'h0)
		else $error("empty set mask");
	a_reset_clear: assert property (disable iff (1'b0) sys_rst |=>
		!reg_ack && !reg_busy && !remote_req && !pend_set_valid && reg_rdata == 32'h0)
		else $error("outputs not cleared by reset");
	c_remote: cover property (remote_req && remote_done);
	c_irq: cover property (pend_set_valid);
	c_write: cover property (tk && reg_we);
endmodule : link_regs_chk

bind link_id_and_interrupt_map_regs link_regs_chk link_regs_chk_i (.clk(clk),
	.sys_rst(sys_rst), .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr),
	.reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_busy(reg_busy),
	.part_identifier_input(part_identifier_input), .part_revision_input(part_revision_input),
	.link_gen2(link_gen2), .pend_set_mask(pend_set_mask), .pend_set_valid(pend_set_valid),
	.remote_req(remote_req), .remote_we(remote_we), .remote_offset(remote_offset),
	.remote_done(remote_done));

// ### remote_peer_model.sv
/*
 * Behavioural remote peer: answers configuration transfers lat+1 cycles after the request rises.
 * Assumes requests stand until remote_done is seen.
 */
`timescale 1ns/1ps
module remote_peer_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic remote_req,
	input wire logic remote_we,
	input wire logic [6:0] remote_offset,
	input wire link_regs_pkg::word_t remote_wdata,
	input wire logic [3:0] lat,
	output logic remote_done,
	output link_regs_pkg::word_t remote_rdata
);
	import link_regs_pkg::*;
	logic [3:0] cnt_q;
	word_t mem_q [32];
	always @(posedge clk) begin
		remote_done <= 1'b0;
		// outside the answer cycle the data lines wander
		remote_rdata <= ~remote_rdata;
		if (sys_rst) begin
			cnt_q <= 4'h0;
		end else if (remote_req && !remote_done) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q >= lat) begin
				remote_done <= 1'b1;
				cnt_q <= 4'h0;
				remote_rdata <= mem_q[remote_offset[6:2]];
				if (remote_we) begin
					mem_q[remote_offset[6:2]] <= remote_wdata;
				end
			end
		end
	end
endmodule : remote_peer_model

// ### tb.sv
/*
 * Self-checking bench for the link register bank.
 * Assumes the bank, its checker and the peer model are compiled first.
 */
`timescale 1ns/1ps
module tb;
	import link_regs_pkg::*;
	logic clk = 0, sys_rst = 1, reg_sel = 0, reg_we = 0, link_gen2 = 0;
	logic reg_ack, reg_busy, pend_set_valid, remote_req, remote_we, remote_done;
	logic en, typ, pol;
	logic [7:0] reg_addr = 8'h0, irq = 8'h0, b, a;
	logic [4:0] vec;
	logic [6:0] remote_offset;
	logic [3:0] lat = 4'h0;
	logic [15:0] pid = 16'h0, prv = 16'h0;
	word_t reg_wdata = 32'h0, reg_rdata, pend_set_mask, remote_wdata, remote_rdata, v;
	int n_errors = 0, compares = 0, seed = 32'h57f515e1;
	word_t exq[$], irq_q[$];
	always #50 clk = ~clk;
	link_id_and_interrupt_map_regs link_id_and_interrupt_map_regs_i (.clk(clk),
		.sys_rst(sys_rst), .reg_sel(reg_sel), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack), .reg_busy(reg_busy),
		.part_identifier_input(pid), .part_revision_input(prv), .link_gen2(link_gen2),
		.external_irq_inputs(irq), .pend_set_mask(pend_set_mask),
		.pend_set_valid(pend_set_valid), .remote_req(remote_req), .remote_we(remote_we),
		.remote_offset(remote_offset), .remote_wdata(remote_wdata),
		.remote_done(remote_done), .remote_rdata(remote_rdata));
	remote_peer_model remote_peer_model_i (.clk(clk), .sys_rst(sys_rst),
		.remote_req(remote_req), .remote_we(remote_we), .remote_offset(remote_offset),
		.remote_wdata(remote_wdata), .lat(lat), .remote_done(remote_done),
		.remote_rdata(remote_rdata));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input word_t e, input word_t g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task automatic final_report;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : final_report
	task automatic acc(input logic w, input logic [7:0] ad, input word_t d, input word_t e);
		int n;
		n = 0;
		exq.push_back(e);
		@(posedge clk);
		reg_sel <= 1'b1;
		reg_we <= w;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge clk);
		reg_sel <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (reg_ack !== 1'b1 && n < 40);
		if (n >= 40) begin
			n_errors++;
			final_report();
		end
	endtask : acc
	////////////////////////////////////////////////////////////////////////////////
	// every answer and every set pulse must match the oldest note
	always @(negedge clk) begin
		if (reg_ack === 1'b1)
			chk("reg_rdata", exq.size() ? exq.pop_front() : 32'hX, reg_rdata);
		if (pend_set_valid === 1'b1)
			chk("pend_set_mask", irq_q.size() ? irq_q.pop_front() : 32'h0, pend_set_mask);
	end
	initial begin
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		acc(0, 8'h60, 0, 0);
		acc(0, 8'h64, 0, 0);
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			v = $random(seed);
			pid <= v[15:0];
			prv <= v[31:16];
			link_gen2 <= i[0];
			acc(1, 8'h40, ~v, 0);
			acc(0, 8'h40, 0, v);
			acc(0, 8'h44, 0, {15'h0, i[0], 16'h0});
			acc(1, 8'h4C, v, 0);
			acc(0, 8'h4C, 0, 32'h1);
			acc(1, 8'h50, v, 0);
			acc(0, 8'h50, 0, 0);
			// enables stay clear: an active-low level input idling low would fire
			acc(1, 8'h60 + 8'(4 * i), v & 32'h7F7F_7F7F, 0);
			acc(0, 8'h60 + 8'(4 * i), 0, v & 32'h7F7F_7F7F);
		end
		for (int i = 0; i < 8; i++) begin
			v = $random(seed);
			vec = (i == 7) ? 5'h1F : v[4:0];
			en = (i != 5);
			typ = (i != 2);
			pol = i[0];
			b = {en, typ, pol, vec};
			@(posedge clk);
			irq[i] <= pol;
			acc(1, (i < 4) ? 8'h60 : 8'h64, word_t'(b) << (8 * (i % 4)), 0);
			repeat (4) @(posedge clk);
			if (en) repeat (typ ? 1 : 3) irq_q.push_back(32'h1 << vec);
			irq[i] <= ~pol;
			repeat (3) @(posedge clk);
			irq[i] <= pol;
			repeat (6) @(posedge clk);
		end
		for (int i = 0; i < 2; i++) begin
			@(posedge clk);
			v = $random(seed);
			a = i ? 8'hFC : 8'h84;
			lat <= i ? 4'h5 : 4'h0;
			acc(1, a, v, 0);
			acc(0, a, 0, v);
		end
		// acc returns in the ack cycle; let the watcher take that last note first
		repeat (2) @(posedge clk);
		chk("notes_left", 32'h0, 32'(exq.size() + irq_q.size()));
		final_report();
	end
endmodule : tb
